/* File: rtl/fpe_pkg.sv */
package fpe_pkg;

    // register map (byte addresses on the 16-bit bus)
    localparam logic [15:0] NVM_CONTROL_ADDR      = 16'hFE08;
    localparam logic [15:0] PROTECT_BOUNDARY_ADDR = 16'hFE0C;
    localparam logic [15:0] SEQ_STATUS_ADDR       = 16'hFE10;

    // nvm_control fields
    localparam int          HIGH_VOLTAGE_ENABLE_BIT      = 3;
    localparam int          MASS_BIT      = 2;
    localparam int          ERASE_BIT     = 1;
    localparam int          PROG_BIT      = 0;
    localparam logic [7:0]  CONTROL_RESET = 8'h00;
    localparam logic [7:0]  BOUNDARY_RESET = 8'hFF;
    localparam logic [7:0]  BOUNDARY_OPEN = 8'hFF;
    localparam logic [7:0]  BOUNDARY_ALL  = 8'h00;

    // seq_status fields
    localparam int          ST_ARMED_BIT  = 0;
    localparam int          ST_HV_BIT     = 1;
    localparam int          ST_SWEEP_BIT  = 2;
    localparam int          ST_READY_BIT  = 3;
    localparam int          ST_LATCH_BIT  = 4;

    // array geometry
    localparam logic [15:0] USER_FIRST    = 16'hBC00;
    localparam logic [15:0] USER_LAST     = 16'hFBFF;
    localparam logic [15:0] VEC_FIRST     = 16'hFFDC;
    localparam logic [15:0] VEC_LAST      = 16'hFFFF;
    localparam logic [15:0] PROT_FIXED_LAST = 16'hBFFF;
    localparam int          USER_BYTES    = 16384;
    localparam int          VEC_BYTES     = 36;
    localparam int          ARRAY_BYTES   = USER_BYTES + VEC_BYTES;
    localparam int          PAGE_BYTES    = 64;
    localparam int          IDX_W         = 15;
    localparam logic [14:0] VEC_IDX       = 15'h4000;
    localparam logic [14:0] LAST_IDX      = 15'h4023;
    localparam logic [5:0]  PAGE_MASK     = 6'h3F;
    localparam logic [7:0]  ERASED_BYTE   = 8'hFF;

    // timing
    localparam int          CLK_MHZ           = 200;
    localparam int          SETUP_DELAY_US    = 10;
    localparam int          RECOVERY_DELAY_US = 1;
    localparam int          CNT_W             = 12;
    localparam logic [11:0] SETUP_CYC    = 12'(SETUP_DELAY_US * CLK_MHZ);
    localparam logic [11:0] RECOVERY_CYC = 12'(RECOVERY_DELAY_US * CLK_MHZ);

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } fpe_mem_req_t;

    typedef enum logic [2:0] {
        SEQ_IDLE,
        SEQ_SELECTED,
        SEQ_CHECKED,
        SEQ_LATCHED,
        SEQ_ARMED,
        SEQ_HIGH_V,
        SEQ_RECOVER
    } fpe_state_t;

    function automatic logic in_array(input logic [15:0] a);
        in_array = (a >= USER_FIRST && a <= USER_LAST) || (a >= VEC_FIRST);
    endfunction

    function automatic logic [14:0] to_index(input logic [15:0] a);
        logic [15:0] d;
        d = (a >= VEC_FIRST) ? (a - VEC_FIRST + 16'(USER_BYTES))
                             : (a - USER_FIRST);
        to_index = d[14:0];
    endfunction

endpackage

/* File: rtl/fpe_protect.sv */
`timescale 1ns/10ps
module fpe_protect (
    input  wire logic [7:0]  boundary,
    input  wire logic [15:0] addr,
    input  wire logic        whole,
    output logic             blocked
);
    import fpe_pkg::*;

    logic [15:0] start;

    assign start = {2'b11, boundary, 6'h00};

    always_comb begin
        if (boundary == BOUNDARY_OPEN) begin
            blocked = 1'b0;
        end else if (whole || boundary == BOUNDARY_ALL) begin
            blocked = 1'b1;
        end else begin
            blocked = (addr >= start) || (addr <= PROT_FIXED_LAST);
        end
    end

endmodule

/* File: rtl/fpe_array.sv */
`timescale 1ns/10ps
module fpe_array (
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic        rd_en,
    input  wire logic [14:0] rd_idx,
    input  wire logic        wr_en,
    input  wire logic [14:0] wr_idx,
    input  wire logic [7:0]  wr_data,
    input  wire logic        erase_start,
    input  wire logic        erase_mass,
    input  wire logic [14:0] erase_idx,
    output logic [7:0]       rdata,
    output logic             sweep_busy
);
    import fpe_pkg::*;

    logic [7:0]  cells [ARRAY_BYTES];
    logic [14:0] ptr_reg;
    logic [14:0] last_reg;

    // erase sweep, one byte per clock
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            ptr_reg    <= 15'h0000;
            last_reg   <= 15'h0000;
            sweep_busy <= 1'b0;
        end else if (erase_start) begin
            sweep_busy <= 1'b1;
            if (erase_mass) begin
                ptr_reg  <= 15'h0000;
                last_reg <= LAST_IDX;
            end else if (erase_idx >= VEC_IDX) begin
                ptr_reg  <= VEC_IDX;
                last_reg <= LAST_IDX;
            end else begin
                ptr_reg  <= {erase_idx[14:6], 6'h00};
                last_reg <= {erase_idx[14:6], PAGE_MASK};
            end
        end else if (sweep_busy) begin
            ptr_reg <= ptr_reg + 15'h0001;
            if (ptr_reg == last_reg) begin
                sweep_busy <= 1'b0;
            end
        end
    end

    // non-volatile cells: no reset; programming only clears bits
    always_ff @(posedge sys_clk) begin
        if (sweep_busy) begin
            cells[ptr_reg] <= ERASED_BYTE;
        end else if (wr_en) begin
            cells[wr_idx] <= cells[wr_idx] & wr_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            rdata <= ERASED_BYTE;
        end else if (rd_en) begin
            rdata <= cells[rd_idx];
        end
    end

endmodule

/* File: rtl/fpe_top.sv */
// Function
// - erased cells read one, programmed cells read zero.
// - array holds 16384 user bytes BC00-FBFF plus 36 vector bytes FFDC-FFFF.
// - user erase page is 64 bytes; the vector page erase covers only 36 bytes.
// - user pages are 64-byte aligned; any single user page erasable alone.
// - whole 36-byte vector area erases as one page.
// - high-voltage bit drives charge pump and array high voltage; readable.
// - high-voltage set only with a mode selected and the sequence done.
// - mass-select picks whole-array (1) or page (0) erase; readable.
// - erase and program selects never both one; such writes refused.
// - control at FE08, reset zero, bits 3..0 hv/mass/erase/program.
// - high voltage never set when the target region is protected.
`timescale 1ns/10ps
module fpe_top (
    input  wire logic                  sys_clk,
    input  wire logic                  resetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [15:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire fpe_pkg::fpe_mem_req_t mem_req,
    output logic [7:0]                 mem_rdata,
    output logic                       mem_rvalid,
    output logic                       charge_pump_on,
    output logic                       array_hv_on,
    output logic                       erase_busy
);
    import fpe_pkg::*;

    fpe_state_t  state_reg;
    fpe_state_t  state_next;
    logic [11:0] cnt_reg;
    logic [7:0]  control_reg;
    logic [7:0]  boundary_reg;
    logic [15:0] latch_addr_reg;
    logic        latch_valid_reg;
    logic        hv_reg;
    logic        mass_reg;
    logic        erase_reg;
    logic        prog_reg;
    logic        access;
    logic        setup;
    logic        hit_ctrl;
    logic        hit_bound;
    logic        hit_status;
    logic        ctrl_wr;
    logic        both_req;
    logic        ctrl_ok;
    logic        mode_change;
    logic        bound_rd;
    logic        mem_hit;
    logic        latch_wr;
    logic        blocked;
    logic        hv_set_ok;
    logic        hv_next;
    logic        hv_fall;
    logic        erase_start;
    logic        prog_wr;
    logic        sweep_busy;
    logic [7:0]  status_val;
    logic [7:0]  rd_val;

    assign hv_reg    = control_reg[HIGH_VOLTAGE_ENABLE_BIT];
    assign mass_reg  = control_reg[MASS_BIT];
    assign erase_reg = control_reg[ERASE_BIT];
    assign prog_reg  = control_reg[PROG_BIT];

    // bus decode
    assign setup      = psel && !penable;
    assign access     = psel && penable && pready;
    assign hit_ctrl   = (paddr == NVM_CONTROL_ADDR);
    assign hit_bound  = (paddr == PROTECT_BOUNDARY_ADDR);
    assign hit_status = (paddr == SEQ_STATUS_ADDR);

    assign ctrl_wr  = access && pwrite && hit_ctrl;
    assign both_req = pwdata[ERASE_BIT] && pwdata[PROG_BIT];
    assign ctrl_ok  = ctrl_wr && !both_req;
    assign mode_change = ctrl_ok &&
        ({pwdata[MASS_BIT], pwdata[ERASE_BIT], pwdata[PROG_BIT]} !=
         {mass_reg, erase_reg, prog_reg});
    assign bound_rd = access && !pwrite && hit_bound;

    assign mem_hit  = mem_req.wr && in_array(mem_req.addr);
    assign latch_wr = (state_reg == SEQ_CHECKED) && mem_hit;

    // protection check on the latched target
    fpe_protect i_fpe_protect (
        .boundary (boundary_reg),
        .addr     (latch_addr_reg),
        .whole    (erase_reg && mass_reg),
        .blocked  (blocked)
    );

    // high voltage only from the armed state, mode selected, not protected
    assign hv_set_ok = (state_reg == SEQ_ARMED) && !mode_change &&
                       (pwdata[ERASE_BIT] || pwdata[PROG_BIT]) &&
                       latch_valid_reg && !blocked;

    always_comb begin
        hv_next = hv_reg;
        if (ctrl_ok) begin
            if (!pwdata[HIGH_VOLTAGE_ENABLE_BIT]) begin
                hv_next = 1'b0;
            end else if (!hv_reg) begin
                hv_next = hv_set_ok;
            end
        end
    end

    assign hv_fall     = hv_reg && !hv_next;
    assign erase_start = !hv_reg && hv_next && pwdata[ERASE_BIT];
    assign prog_wr     = (state_reg == SEQ_HIGH_V) && hv_reg && prog_reg &&
                         mem_hit && !blocked;

    // control register
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            control_reg <= CONTROL_RESET;
        end else if (ctrl_ok) begin
            control_reg <= {4'h0, hv_next, pwdata[MASS_BIT],
                            pwdata[ERASE_BIT], pwdata[PROG_BIT]};
        end
    end

    // stands in for the non-volatile boundary byte
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            boundary_reg <= BOUNDARY_RESET;
        end else if (access && pwrite && hit_bound) begin
            boundary_reg <= pwdata[7:0];
        end
    end

    // target address capture
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            latch_addr_reg  <= 16'h0000;
            latch_valid_reg <= 1'b0;
        end else if (latch_wr) begin
            latch_addr_reg  <= mem_req.addr;
            latch_valid_reg <= 1'b1;
        end else if (state_reg == SEQ_IDLE) begin
            latch_valid_reg <= 1'b0;
        end
    end

    // sequence tracking
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            SEQ_IDLE: begin
                if (erase_reg || prog_reg) begin
                    state_next = SEQ_SELECTED;
                end
            end
            SEQ_SELECTED, SEQ_CHECKED, SEQ_LATCHED, SEQ_ARMED: begin
                if (!(erase_reg || prog_reg)) begin
                    state_next = SEQ_IDLE;
                end else if (mode_change) begin
                    state_next = SEQ_SELECTED;
                end else if (state_reg == SEQ_SELECTED && bound_rd) begin
                    state_next = SEQ_CHECKED;
                end else if (latch_wr) begin
                    state_next = SEQ_LATCHED;
                end else if (state_reg == SEQ_LATCHED &&
                             cnt_reg == SETUP_CYC - 12'h001) begin
                    state_next = SEQ_ARMED;
                end else if (state_reg == SEQ_ARMED && hv_next) begin
                    state_next = SEQ_HIGH_V;
                end
            end
            SEQ_HIGH_V: begin
                if (hv_fall) begin
                    state_next = SEQ_RECOVER;
                end
            end
            SEQ_RECOVER: begin
                if (cnt_reg == RECOVERY_CYC - 12'h001) begin
                    state_next = SEQ_IDLE;
                end
            end
            default: begin
                state_next = SEQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            state_reg <= SEQ_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // cycles spent in the current state
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            cnt_reg <= 12'h000;
        end else if (state_next != state_reg) begin
            cnt_reg <= 12'h000;
        end else if (cnt_reg != 12'hFFF) begin
            cnt_reg <= cnt_reg + 12'h001;
        end
    end

    fpe_array i_fpe_array (
        .sys_clk     (sys_clk),
        .resetn      (resetn),
        .rd_en       (mem_req.rd && in_array(mem_req.addr)),
        .rd_idx      (to_index(mem_req.addr)),
        .wr_en       (prog_wr),
        .wr_idx      (to_index(mem_req.addr)),
        .wr_data     (mem_req.wdata),
        .erase_start (erase_start),
        .erase_mass  (pwdata[MASS_BIT]),
        .erase_idx   (to_index(latch_addr_reg)),
        .rdata       (mem_rdata),
        .sweep_busy  (sweep_busy)
    );

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            mem_rvalid <= 1'b0;
        end else begin
            mem_rvalid <= mem_req.rd && in_array(mem_req.addr);
        end
    end

    // pump and array supply follow the bit
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            charge_pump_on <= 1'b0;
            array_hv_on    <= 1'b0;
            erase_busy     <= 1'b0;
        end else begin
            charge_pump_on <= hv_next;
            array_hv_on    <= hv_next;
            erase_busy     <= sweep_busy;
        end
    end

    always_comb begin
        status_val = 8'h00;
        status_val[ST_ARMED_BIT] = (state_reg == SEQ_ARMED);
        status_val[ST_HV_BIT]    = hv_reg;
        status_val[ST_SWEEP_BIT] = sweep_busy;
        status_val[ST_READY_BIT] = !hv_reg && state_reg != SEQ_RECOVER;
        status_val[ST_LATCH_BIT] = latch_valid_reg;
    end

    always_comb begin
        rd_val = 8'h00;
        if (hit_ctrl) begin
            rd_val = control_reg;
        end else if (hit_bound) begin
            rd_val = boundary_reg;
        end else if (hit_status) begin
            rd_val = status_val;
        end
    end

    // apb answer: ready in the first access cycle
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup;
            pslverr <= setup && !(hit_ctrl || hit_bound || hit_status);
            if (setup && !pwrite) begin
                prdata <= {24'h00_0000, rd_val};
            end else if (setup) begin
                prdata <= 32'h0000_0000;
            end
        end
    end

endmodule

/* File: tb/fpe_top_sva.sv */
`timescale 1ns/10ps
module fpe_top_sva (
    input wire logic                  sys_clk,
    input wire logic                  resetn,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [15:0]           paddr,
    input wire logic [31:0]           pwdata,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    input wire fpe_pkg::fpe_mem_req_t mem_req,
    input wire logic [7:0]            mem_rdata,
    input wire logic                  mem_rvalid,
    input wire logic                  charge_pump_on,
    input wire logic                  array_hv_on,
    input wire logic                  erase_busy
);
    import fpe_pkg::*;
    logic ctl_wr;
    logic unmapped;
    assign ctl_wr = psel && penable && pready && pwrite
                    && paddr == NVM_CONTROL_ADDR;
    assign unmapped = paddr != NVM_CONTROL_ADDR
                      && paddr != PROTECT_BOUNDARY_ADDR
                      && paddr != SEQ_STATUS_ADDR;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    a_pump_pair: assert property (charge_pump_on == array_hv_on)
        else $error("pump and array high voltage differ");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    a_ready_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_err_decode: assert property (psel && !penable
        |=> pslverr == $past(unmapped))
        else $error("error flag does not match decode");
    a_ctrl_read: assert property (pready && !pwrite && !pslverr
        && paddr == NVM_CONTROL_ADDR |-> prdata[31:4] == '0
        && prdata[1:0] != 2'h3)
        else $error("control read shows bad bits");
    a_hv_rise: assert property ($rose(charge_pump_on)
        |-> ($past(ctl_wr) && $past(pwdata[HIGH_VOLTAGE_ENABLE_BIT]))
        || ($past(ctl_wr, 2) && $past(pwdata[HIGH_VOLTAGE_ENABLE_BIT], 2)))
        else $error("high voltage rose without a write");
    a_hv_clear: assert property (ctl_wr && !pwdata[HIGH_VOLTAGE_ENABLE_BIT]
        && pwdata[1:0] != 2'h3 |-> ##[1:3] !charge_pump_on)
        else $error("high voltage not removed");
    a_rvalid_rd: assert property (mem_req.rd
        && in_array(mem_req.addr) |=> mem_rvalid)
        else $error("array read not answered");
    a_rvalid_cause: assert property (mem_rvalid
        |-> $past(mem_req.rd))
        else $error("read valid without a read");
    a_busy_hv: assert property ($rose(erase_busy)
        |-> charge_pump_on)
        else $error("sweep without high voltage");
endmodule
bind fpe_top fpe_top_sva i_fpe_top_sva (.sys_clk, .resetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .mem_req,
    .mem_rdata, .mem_rvalid, .charge_pump_on, .array_hv_on, .erase_busy);

/* File: tb/flash_page_erase_control_test.sv */
`timescale 1ns/10ps
module flash_page_erase_control_test;
    import fpe_pkg::*;
    logic         sys_clk;
    logic         resetn;
    logic         psel;
    logic         penable;
    logic         pwrite;
    logic [15:0]  paddr;
    logic [31:0]  pwdata;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    fpe_mem_req_t mem_req;
    logic [7:0]   mem_rdata;
    logic         mem_rvalid;
    logic         charge_pump_on;
    logic         array_hv_on;
    logic         erase_busy;
    logic [31:0]  rd;
    logic         err;
    int           errors;
    int           compares;
    int           n;
    logic [15:0]  pg_addr [4] = '{16'hBC7F, 16'hBC80, 16'hFFDC, 16'hFFFF};

    fpe_top i_fpe_top (.sys_clk, .resetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .mem_req, .mem_rdata,
        .mem_rvalid, .charge_pump_on, .array_hv_on, .erase_busy);

    initial begin
        sys_clk = 1'h0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    task end_sim;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp, input string s);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: %s got %0h", $time, s, got);
        end
    endtask

    task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        int k;
        @(posedge sys_clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'h1;
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (pready !== 1'h1 && k < 50);
        if (k >= 50) begin
            errors++;
            end_sim();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task mem(input logic w, input logic [15:0] a, input logic [7:0] d);
        int k;
        @(posedge sys_clk);
        mem_req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge sys_clk);
        mem_req <= '0;
        k = 0;
        while (!w && mem_rvalid !== 1'h1 && k < 8) begin
            @(posedge sys_clk);
            k++;
        end
        if (!w && mem_rvalid !== 1'h1) begin
            errors++;
            end_sim();
        end
        rd = {24'h0, mem_rdata};
    endtask

    // select, check boundary, latch target, wait out setup, raise voltage
    task seq(input logic [7:0] m, input logic [15:0] a);
        apb(1'h1, NVM_CONTROL_ADDR, {24'h0, m});
        apb(1'h0, PROTECT_BOUNDARY_ADDR, 32'h0);
        mem(1'h1, a, 8'hFF);
        repeat (2010) @(posedge sys_clk);
        apb(1'h1, NVM_CONTROL_ADDR, {24'h0, m | 8'h08});
    endtask

    task hv_off;
        apb(1'h1, NVM_CONTROL_ADDR, 32'h08);
        repeat (1000) @(posedge sys_clk);
        apb(1'h1, NVM_CONTROL_ADDR, 32'h00);
        repeat (210) @(posedge sys_clk);
    endtask

    task sweep;
        int k;
        k = 0;
        n = 0;
        while (erase_busy !== 1'h1 && k < 8) begin
            @(posedge sys_clk);
            k++;
        end
        if (erase_busy !== 1'h1) begin
            errors++;
            end_sim();
        end
        while (erase_busy === 1'h1 && n < 20000) begin
            @(posedge sys_clk);
            n++;
        end
    endtask

    initial begin
        resetn = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 16'h0;
        pwdata = 32'h0;
        mem_req = '0;
        errors = 0;
        compares = 0;
        repeat (6) @(posedge sys_clk);
        resetn <= 1'h1;
        apb(1'h0, NVM_CONTROL_ADDR, 32'h0);
        chk(rd, 32'h0, "control reset");
        apb(1'h0, PROTECT_BOUNDARY_ADDR, 32'h0);
        chk(rd, 32'hFF, "boundary reset");
        apb(1'h0, 16'hFE04, 32'h0);
        chk(err, 1'h1, "unmapped error");
        apb(1'h0, SEQ_STATUS_ADDR, 32'h0);
        chk(rd, 32'h08, "idle status");
        $display("test reset done");
        apb(1'h1, NVM_CONTROL_ADDR, 32'h03);
        apb(1'h0, NVM_CONTROL_ADDR, 32'h0);
        chk(rd, 32'h0, "both selects from idle");
        apb(1'h1, NVM_CONTROL_ADDR, 32'h01);
        apb(1'h1, NVM_CONTROL_ADDR, 32'h03);
        apb(1'h0, NVM_CONTROL_ADDR, 32'h0);
        chk(rd, 32'h01, "both selects refused");
        apb(1'h1, NVM_CONTROL_ADDR, 32'h09);
        apb(1'h0, NVM_CONTROL_ADDR, 32'h0);
        chk(rd, 32'h01, "early voltage ignored");
        chk(charge_pump_on, 1'h0, "early pump");
        apb(1'h1, NVM_CONTROL_ADDR, 32'h0);
        $display("test interlock done");
        seq(8'h01, 16'hBC40);
        apb(1'h0, NVM_CONTROL_ADDR, 32'h0);
        chk(rd, 32'h09, "program voltage on");
        chk(charge_pump_on, 1'h1, "pump on");
        chk(array_hv_on, 1'h1, "array voltage on");
        foreach (pg_addr[j]) mem(1'h1, pg_addr[j], 8'h00);
        hv_off();
        chk(charge_pump_on, 1'h0, "pump off");
        chk(array_hv_on, 1'h0, "array voltage off");
        mem(1'h0, 16'hBC80, 8'h0);
        chk(rd, 32'h00, "programmed byte");
        $display("test program done");
        seq(8'h02, 16'hBC55);
        sweep();
        chk(n, PAGE_BYTES, "page sweep");
        hv_off();
        mem(1'h0, 16'hBC7F, 8'h0);
        chk(rd, 32'hFF, "erased page end");
        mem(1'h0, 16'hBC80, 8'h0);
        chk(rd, 32'h00, "next page kept");
        $display("test page erase done");
        seq(8'h02, 16'hFFE0);
        sweep();
        chk(n, VEC_BYTES, "vector sweep");
        hv_off();
        mem(1'h0, 16'hFFDC, 8'h0);
        chk(rd, 32'hFF, "vector first");
        mem(1'h0, 16'hFFFF, 8'h0);
        chk(rd, 32'hFF, "vector last");
        $display("test vector erase done");
        apb(1'h1, PROTECT_BOUNDARY_ADDR, 32'h00);
        seq(8'h02, 16'hBC55);
        apb(1'h0, NVM_CONTROL_ADDR, 32'h0);
        chk(rd, 32'h02, "protected voltage refused");
        chk(charge_pump_on, 1'h0, "protected pump");
        apb(1'h0, SEQ_STATUS_ADDR, 32'h0);
        chk(rd, 32'h19, "armed status");
        apb(1'h1, NVM_CONTROL_ADDR, 32'h0);
        apb(1'h1, PROTECT_BOUNDARY_ADDR, 32'hFF);
        $display("test protect done");
        seq(8'h06, 16'hBC00);
        sweep();
        chk(n, ARRAY_BYTES, "mass sweep");
        hv_off();
        mem(1'h0, 16'hBC80, 8'h0);
        chk(rd, 32'hFF, "mass erased");
        $display("test mass erase done");
        end_sim();
    end

endmodule
